// ==== csr_link_cfg.svh ====
// offsets, field positions, codes and timing counts for the clock sync link
// assumes a 200 MHz pclk and a 32-bit apb data path
`ifndef CSR_LINK_CFG_SVH
`define CSR_LINK_CFG_SVH

`define SRV_WKA 24'h0FFFF6
`define FABRIC_WKA 24'h0FFFFD
`define REQ_CMD 8'h68
`define REQ_W0 32'h68000000
`define ACC_W0 32'h02000000
`define RJT_W0 32'h01000000
`define MODE_BASIC 8'h00
`define MODE_PARAM 8'h01
`define MODE_OFF 8'hFF
`define MODE_POS 24
`define ACC_POS 16
`define ACC_MANT_HI 23
`define ACC_MANT_LO 21
`define ACC_EXP_HI 20
`define ACC_EXP_LO 16
`define MSB_POS 8
`define LSB_POS 0
`define BIT_IDX_MAX 8'h3F
`define CLK_PERIOD_PS 5000
`define US_PS 1000000
`define CYC_PER_US (`US_PS / `CLK_PERIOD_PS)

`define OFF_CTRL 8'h00
`define OFF_REQ_W1 8'h04
`define OFF_REQ_PERIOD 8'h08
`define OFF_DEST 8'h0C
`define OFF_SRC_ID 8'h10
`define OFF_STATUS 8'h14
`define OFF_RSP_W1 8'h18
`define OFF_RSP_W2 8'h1C
`define OFF_UPD_HI 8'h20
`define OFF_UPD_LO 8'h24
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ACCEPT 2
`define ST_UPD 3

`endif

// ==== csr_link_pkg.sv ====
// types shared by both ends of the clock sync request link
// assumes csr_link_cfg.svh for all numbers
package csr_link_pkg;

  typedef enum logic [1:0] {DEV_IDLE, DEV_CHECK, DEV_REPLY} dev_state_e;
  typedef enum logic [1:0] {CLI_IDLE, CLI_SEND, CLI_WAIT} cli_state_e;

  typedef struct packed {
    dev_state_e st;
    logic [23:0] s_id;
    logic dst_fc;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] period;
    logic rsp_valid;
    logic rsp_accept;
    logic [31:0] rsp_w0;
    logic [31:0] rsp_w1;
    logic [31:0] rsp_w2;
    logic svc_on;
    logic [23:0] svc_client;
    logic [5:0] g_msb;
    logic [5:0] g_lsb;
    logic [31:0] g_period;
    logic [7:0] us_cnt;
    logic [31:0] per_cnt;
    logic upd_valid;
    logic [63:0] upd_count;
  } dev_regs_s;

  typedef struct packed {
    cli_state_e st;
    logic [31:0] req_w1;
    logic [31:0] req_period;
    logic dest_fc;
    logic [23:0] src_id;
    logic done;
    logic accepted;
    logic upd_seen;
    logic [31:0] rsp_w1;
    logic [31:0] rsp_w2;
    logic [63:0] upd_count;
    logic [31:0] prdata;
  } cli_regs_s;

endpackage

// ==== csr_link_if.sv ====
// parallel link between the requesting client and the clock sync server
// assumes both ends share pclk; each valid is a one-cycle pulse
`timescale 1ns/1ps
interface csr_link_if;
  logic req_valid;
  logic [23:0] req_s_id;
  logic [23:0] req_d_id;
  logic [31:0] req_w0;
  logic [31:0] req_w1;
  logic [31:0] req_w2;
  logic rsp_valid;
  logic rsp_accept;
  logic [31:0] rsp_w0;
  logic [31:0] rsp_w1;
  logic [31:0] rsp_w2;
  logic upd_valid;
  logic [23:0] upd_d_id;
  logic [63:0] upd_count;

  modport server (
    input req_valid, req_s_id, req_d_id, req_w0, req_w1, req_w2,
    output rsp_valid, rsp_accept, rsp_w0, rsp_w1, rsp_w2,
    output upd_valid, upd_d_id, upd_count
  );
  modport client (
    output req_valid, req_s_id, req_d_id, req_w0, req_w1, req_w2,
    input rsp_valid, rsp_accept, rsp_w0, rsp_w1, rsp_w2,
    input upd_valid, upd_d_id, upd_count
  );
endinterface

// ==== count_mask.sv ====
// zeroes count bits outside the granted top..bottom index range
// assumes top and bottom are already within 0..63
`timescale 1ns/1ps
module count_mask (
  input wire logic [63:0] count_in,
  input wire logic [5:0] top_idx,
  input wire logic [5:0] bot_idx,
  output logic [63:0] count_out
);
  genvar i;
  generate
    for (i = 0; i < 64; i++) begin : g_bit
      assign count_out[i] = count_in[i] & (6'(i) <= top_idx) &
                            (6'(i) >= bot_idx); // R18
    end
  endgenerate
endmodule

// ==== csr_server.sv ====
// clock sync server and fabric controller end of the request link
// assumes requests arrive as single pulses and the local count is in pclk
//
// What this block does
// R1: client sources own id, addresses server/fabric
// R2: word 0 is 68h then zeros
// R3: server modes: 00h, 01h enable; FFh disable
// R4: fabric modes 00h, 01h return service parameters
// R5: accuracy byte is mantissa 23-21, exponent 20-16
// R6: report own accuracy code honestly
// R7: requested top index within 0 to 63
// R8: requested bottom index within 0 to 63
// R9: requested update interval in microseconds
// R10: declined request gets a reject
// R11: accept word 0 is 02h then zeros
// R12: accept mode echoes the request mode
// R13: accept mode 00h enabled, FFh disabled
// R14: accept top index is highest filled bit
// R15: accept bottom index is lowest filled bit
// R16: accept interval is actual update spacing (a granted period 0 is reported as 0, yet updates come every 1 us)
// R17: updates carry count; clients never reply
// R18: zero count bits outside granted range
// R19: reserved mode rejected, service state unchanged
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "csr_link_cfg.svh"
module csr_server
  import csr_link_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  csr_link_if.server link,
  input wire logic srv_allow,
  input wire logic [7:0] srv_accuracy,
  input wire logic [5:0] srv_top_idx,
  input wire logic [5:0] srv_bot_idx,
  input wire logic [31:0] srv_period_us,
  input wire logic [63:0] clock_count,
  output logic service_on,
  output logic [23:0] service_client
);
  localparam logic [7:0] US_LAST = 8'(`CYC_PER_US - 1);

  dev_regs_s r_reg;
  dev_regs_s r_next;
  logic [63:0] masked;
  logic [7:0] mode;
  logic [7:0] rq_top;
  logic [7:0] rq_bot;
  logic hdr_ok;
  logic fields_ok;
  logic mode_ok;
  logic ok;
  logic [5:0] top_g;
  logic [5:0] bot_g;
  logic [31:0] per_g;
  logic [31:0] per_last;
  logic us_wrap;
  logic per_wrap;
  logic restart;

  // the legal mode set depends on which well-known address was hit
  function automatic logic mode_legal(input logic [7:0] m,
                                      input logic fabric);
    logic enable_code;
    enable_code = (m == `MODE_BASIC) || (m == `MODE_PARAM);
    if (fabric) begin
      return enable_code; // R4
    end
    return enable_code || (m == `MODE_OFF); // R3
  endfunction

  function automatic logic is_fabric(input logic [23:0] d_id);
    return d_id == `FABRIC_WKA;
  endfunction

  count_mask u_mask (
    .count_in(clock_count),
    .top_idx(r_reg.g_msb),
    .bot_idx(r_reg.g_lsb),
    .count_out(masked)
  );

  always_comb begin
    mode = r_reg.w1[`MODE_POS +: 8];
    rq_top = r_reg.w1[`MSB_POS +: 8];
    rq_bot = r_reg.w1[`LSB_POS +: 8];
    hdr_ok = (r_reg.w0 == `REQ_W0); // R2
    // requested fields only matter in mode 01h
    fields_ok = (mode != `MODE_PARAM) ||
                ((rq_top <= `BIT_IDX_MAX) && (rq_bot <= `BIT_IDX_MAX) &&
                 (rq_bot <= rq_top)); // R7 R8
    mode_ok = mode_legal(mode, r_reg.dst_fc); // R3 R4
    ok = hdr_ok && fields_ok && mode_ok && srv_allow; // R10 R19
    // grant the narrower of requested and implemented ranges
    top_g = srv_top_idx;
    bot_g = srv_bot_idx;
    per_g = srv_period_us;
    if (mode == `MODE_PARAM) begin
      if (rq_top[5:0] < srv_top_idx) begin
        top_g = rq_top[5:0];
      end
      if (rq_bot[5:0] > srv_bot_idx) begin
        bot_g = rq_bot[5:0];
      end
      if (r_reg.period > srv_period_us) begin
        per_g = r_reg.period; // R9
      end
    end
    if (top_g < bot_g) begin
      top_g = bot_g;
    end
    per_last = (r_reg.g_period == 32'h00000000) ? 32'h00000000 :
               r_reg.g_period - 32'h00000001;
    us_wrap = (r_reg.us_cnt == US_LAST);
    // period 0 acts as 1 us since per_last then stays 0
    per_wrap = (r_reg.per_cnt >= per_last);

    r_next = r_reg;
    r_next.rsp_valid = 1'b0;
    r_next.upd_valid = 1'b0;
    restart = 1'b0;
    unique case (r_reg.st)
      DEV_IDLE: begin
        if (link.req_valid && (is_fabric(link.req_d_id) ||
                               (link.req_d_id == `SRV_WKA))) begin
          r_next.st = DEV_CHECK;
          r_next.s_id = link.req_s_id;
          r_next.dst_fc = is_fabric(link.req_d_id);
          r_next.w0 = link.req_w0;
          r_next.w1 = link.req_w1;
          r_next.period = link.req_w2;
        end
      end
      DEV_CHECK: begin
        r_next.st = DEV_REPLY;
        r_next.rsp_valid = 1'b1;
        r_next.rsp_accept = ok;
        if (ok) begin
          r_next.rsp_w0 = `ACC_W0; // R11
          r_next.rsp_w1 = {mode, srv_accuracy, 2'b00, top_g, 2'b00,
                           bot_g}; // R12 R5 R6 R14 R15
          r_next.rsp_w2 = per_g; // R16
          if (!r_reg.dst_fc && (mode == `MODE_OFF)) begin
            // another client's disable leaves the served one alone
            if (r_reg.s_id == r_reg.svc_client) begin
              r_next.svc_on = 1'b0; // R13
            end
          end else if (!r_reg.dst_fc) begin
            r_next.svc_on = 1'b1; // R13
            r_next.svc_client = r_reg.s_id;
            r_next.g_msb = top_g;
            r_next.g_lsb = bot_g;
            r_next.g_period = per_g;
            restart = 1'b1;
          end
        end else begin
          r_next.rsp_w0 = `RJT_W0; // R10 R19
          r_next.rsp_w1 = 32'h00000000;
          r_next.rsp_w2 = 32'h00000000;
        end
      end
      DEV_REPLY: begin
        r_next.st = DEV_IDLE;
      end
      // the unused state code falls back to idle
      default: begin
        r_next.st = DEV_IDLE;
      end
    endcase

    // update pacing in microseconds, one update per granted period
    // a fresh grant restarts pacing from zero
    if (restart) begin
      r_next.us_cnt = 8'h00;
      r_next.per_cnt = 32'h00000000;
    end else if (r_reg.svc_on) begin
      if (us_wrap) begin
        r_next.us_cnt = 8'h00;
        if (per_wrap) begin
          r_next.per_cnt = 32'h00000000;
          r_next.upd_valid = 1'b1; // R17
          r_next.upd_count = masked; // R18
        end else begin
          r_next.per_cnt = r_reg.per_cnt + 32'h00000001;
        end
      end else begin
        r_next.us_cnt = r_reg.us_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.rsp_valid = r_reg.rsp_valid;
  assign link.rsp_accept = r_reg.rsp_accept;
  assign link.rsp_w0 = r_reg.rsp_w0;
  assign link.rsp_w1 = r_reg.rsp_w1;
  assign link.rsp_w2 = r_reg.rsp_w2;
  assign link.upd_valid = r_reg.upd_valid;
  assign link.upd_d_id = r_reg.svc_client;
  assign link.upd_count = r_reg.upd_count;
  assign service_on = r_reg.svc_on;
  assign service_client = r_reg.svc_client;
endmodule

// ==== csr_client.sv ====
// client port controller: software orders requests over apb
// assumes one outstanding request at a time; no reply to updates is sent
`timescale 1ns/1ps
`include "csr_link_cfg.svh"
module csr_client
  import csr_link_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  csr_link_if.client link
);
  cli_regs_s r_reg;
  cli_regs_s r_next;
  logic wr;
  logic [7:0] off;
  logic mapped;
  logic [31:0] rd;

  always_comb begin
    off = paddr[7:0];
    wr = psel && penable && pwrite;
    mapped = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'b00) &&
             (off <= `OFF_UPD_LO);
    unique case (off)
      `OFF_REQ_W1: rd = r_reg.req_w1;
      `OFF_REQ_PERIOD: rd = r_reg.req_period;
      `OFF_DEST: rd = {31'h00000000, r_reg.dest_fc};
      `OFF_SRC_ID: rd = {8'h00, r_reg.src_id};
      `OFF_STATUS: rd = {28'h0000000, r_reg.upd_seen, r_reg.accepted,
                         r_reg.done, (r_reg.st != CLI_IDLE)};
      `OFF_RSP_W1: rd = r_reg.rsp_w1;
      `OFF_RSP_W2: rd = r_reg.rsp_w2;
      `OFF_UPD_HI: rd = r_reg.upd_count[63:32];
      `OFF_UPD_LO: rd = r_reg.upd_count[31:0];
      default: rd = 32'h00000000;
    endcase

    r_next = r_reg;
    // read data is fetched in the setup cycle so pready can stay high
    if (psel && !penable && !pwrite) begin
      r_next.prdata = rd;
    end
    if (wr && mapped) begin
      unique case (off)
        `OFF_REQ_W1: r_next.req_w1 = pwdata;
        `OFF_REQ_PERIOD: r_next.req_period = pwdata;
        `OFF_DEST: r_next.dest_fc = pwdata[0];
        `OFF_SRC_ID: r_next.src_id = pwdata[23:0];
        `OFF_STATUS: begin
          if (pwdata[`ST_DONE]) begin
            r_next.done = 1'b0;
          end
          if (pwdata[`ST_UPD]) begin
            r_next.upd_seen = 1'b0;
          end
        end
        default: ;
      endcase
    end

    unique case (r_reg.st)
      CLI_IDLE: begin
        // start while busy is ignored
        if (wr && (off == `OFF_CTRL) && mapped && pwdata[0]) begin
          r_next.st = CLI_SEND;
        end
      end
      CLI_SEND: begin
        r_next.st = CLI_WAIT;
      end
      CLI_WAIT: begin
        if (link.rsp_valid) begin
          r_next.st = CLI_IDLE;
          r_next.done = 1'b1;
          r_next.accepted = link.rsp_accept;
          r_next.rsp_w1 = link.rsp_w1;
          r_next.rsp_w2 = link.rsp_w2;
        end
      end
    endcase

    // updates are only recorded, never answered
    if (link.upd_valid && (link.upd_d_id == r_reg.src_id)) begin
      r_next.upd_seen = 1'b1; // R17
      r_next.upd_count = link.upd_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign link.req_valid = (r_reg.st == CLI_SEND);
  assign link.req_s_id = r_reg.src_id; // R1
  assign link.req_d_id = r_reg.dest_fc ? `FABRIC_WKA : `SRV_WKA; // R1
  assign link.req_w0 = `REQ_W0; // R2
  assign link.req_w1 = r_reg.req_w1; // R5 R7 R8
  assign link.req_w2 = r_reg.req_period; // R9
endmodule

// ==== csr_link_monitor.sv ====
// assertions on the link between client and server
// assumes one pclk domain and active-low presetn
`timescale 1ns/1ps
`include "csr_link_cfg.svh"
module csr_link_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req_valid,
  input wire logic [23:0] req_d_id,
  input wire logic [31:0] req_w1,
  input wire logic rsp_valid,
  input wire logic rsp_accept,
  input wire logic [31:0] rsp_w0,
  input wire logic [31:0] rsp_w1,
  input wire logic upd_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] md;
  logic ok;
  assign md = req_w1[31:24];
  assign ok = rsp_valid && rsp_accept;
  property p_lat;
    req_valid |-> ##1 !rsp_valid ##1 rsp_valid;
  endproperty
  a_lat: assert property (p_lat) else $error("reply late");
  property p_acc;
    ok |-> rsp_w0 == `ACC_W0;
  endproperty
  a_acc: assert property (p_acc) else $error("accept word");
  property p_rej;
    rsp_valid && !rsp_accept |-> rsp_w0 == `RJT_W0 && rsp_w1 == 32'h0;
  endproperty
  a_rej: assert property (p_rej) else $error("reject words");
  property p_echo;
    logic [7:0] m;
    (req_valid, m = md) ##2 ok |-> rsp_w1[31:24] == m;
  endproperty
  a_echo: assert property (p_echo) else $error("mode echo");
  property p_srv;
    req_valid && req_d_id == `SRV_WKA && md > 8'h01 && md != `MODE_OFF
      |-> ##2 !rsp_accept;
  endproperty
  a_srv: assert property (p_srv) else $error("server mode");
  property p_fab;
    req_valid && req_d_id == `FABRIC_WKA && md > 8'h01 |-> ##2 !rsp_accept;
  endproperty
  a_fab: assert property (p_fab) else $error("fabric mode");
  property p_idx;
    ok |-> rsp_w1[15:8] <= `BIT_IDX_MAX && rsp_w1[7:0] <= `BIT_IDX_MAX &&
      rsp_w1[7:0] <= rsp_w1[15:8];
  endproperty
  a_idx: assert property (p_idx) else $error("index range");
  property p_hold;
    !rsp_valid |-> $stable(rsp_accept);
  endproperty
  a_hold: assert property (p_hold) else $error("accept moved");
  c_acc: cover property (ok);
  c_rej: cover property (rsp_valid && !rsp_accept);
  c_upd: cover property (upd_valid);
endmodule

// ==== clock_sync_request_handler_test.sv ====
// bench: client and server joined by the link, apb drives the client
// assumes 200 MHz pclk; waits are bounded loops
`timescale 1ns/1ps
`include "csr_link_cfg.svh"
module clock_sync_request_handler_test;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [31:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, rd_v, st;
  logic pready, pslverr, err, service_on;
  logic srv_allow = 1;
  logic [5:0] srv_top = 6'h3F;
  logic [5:0] srv_bot = 6'h00;
  logic [31:0] srv_per = 32'h1;
  logic [23:0] service_client;
  // upper bits set so the mask shows in updates
  logic [63:0] clock_count = 64'hFFFFFFFF_FFFF0000;
  int bad_count = 0;
  int samples_checked = 0;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) clock_count <= clock_count + 64'h1;
  csr_link_if lk ();
  csr_client csr_client_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk));
  csr_server csr_server_i (.pclk(pclk), .presetn(presetn), .link(lk),
    .srv_allow(srv_allow), .srv_accuracy(8'h45), .srv_top_idx(srv_top),
    .srv_bot_idx(srv_bot), .srv_period_us(srv_per),
    .clock_count(clock_count),
    .service_on(service_on), .service_client(service_client));
  csr_link_monitor csr_link_monitor_i (.pclk(pclk), .presetn(presetn),
    .req_valid(lk.req_valid), .req_d_id(lk.req_d_id), .req_w1(lk.req_w1),
    .rsp_valid(lk.rsp_valid), .rsp_accept(lk.rsp_accept),
    .rsp_w0(lk.rsp_w0), .rsp_w1(lk.rsp_w1), .upd_valid(lk.upd_valid));
  task results;
    $display("checks %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task ck(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      results();
    end
    rd_v = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // polls status until bit b is set; leaves status in st
  task poll(input int b, input int lim);
    int n;
    n = 0;
    st = 0;
    while (st[b] !== 1'b1) begin
      if (n >= lim) begin
        bad_count++;
        results();
      end
      apb(0, `OFF_STATUS, 0);
      st = rd_v;
      n++;
    end
  endtask
  task req(input logic f, input logic [31:0] w1, p, input logic ea);
    apb(1, `OFF_REQ_W1, w1);
    apb(1, `OFF_REQ_PERIOD, p);
    apb(1, `OFF_DEST, {31'h0, f});
    apb(1, `OFF_CTRL, 32'h1);
    poll(`ST_DONE, 20);
    apb(1, `OFF_STATUS, 32'h2);
    ck("accept", {31'h0, ea}, {31'h0, st[`ST_ACCEPT]});
    apb(0, `OFF_RSP_W1, 0);
  endtask
  task t_enable;
    req(0, 32'h012B3708, 32'h3, 1);
    ck("w1", 32'h01453708, rd_v);
    apb(0, `OFF_RSP_W2, 0);
    ck("w2", 32'h3, rd_v);
    ck("on", 32'h1, {31'h0, service_on});
    ck("who", 32'h00010203, {8'h0, service_client});
  endtask
  task t_update;
    poll(`ST_UPD, 700);
    apb(0, `OFF_UPD_HI, 0);
    ck("hi", 32'h00FFFFFF, rd_v);
    apb(0, `OFF_UPD_LO, 0);
    ck("lo", 32'h0, {24'h0, rd_v[7:0]});
  endtask
  task t_reserved;
    logic [31:0] w [5];
    w = '{32'h02000000, 32'h80000000, 32'hFE000000, 32'h01004000,
          32'h01000810};
    foreach (w[i]) begin
      req(0, w[i], 0, 0);
      ck("keep", 32'h1, {31'h0, service_on});
    end
  endtask
  task t_fabric;
    req(1, 32'h00000000, 0, 1);
    req(1, 32'h01000000, 0, 1);
    req(1, 32'hFF000000, 0, 0);
    ck("keep", 32'h1, {31'h0, service_on});
  endtask
  task t_modes;
    req(0, 32'hFF000000, 0, 1);
    ck("off", 32'h0, {31'h0, service_on});
    req(0, 32'h00123456, 32'h9, 1);
    ck("w1", 32'h00453F00, rd_v);
    apb(0, `OFF_RSP_W2, 0);
    ck("w2", 32'h1, rd_v);
    ck("on", 32'h1, {31'h0, service_on});
    srv_allow <= 0;
    req(0, 32'hFF000000, 0, 0);
    ck("kept", 32'h1, {31'h0, service_on});
    srv_allow <= 1;
    req(0, 32'hFF000000, 0, 1);
    ck("off", 32'h0, {31'h0, service_on});
  endtask
  // server narrower than the request, then a crossed range, then a stranger
  task t_narrow;
    srv_top <= 6'h30;
    srv_bot <= 6'h10;
    srv_per <= 32'h20;
    req(0, 32'h01453F00, 32'h5, 1);
    ck("nw1", 32'h01453010, rd_v);
    apb(0, `OFF_RSP_W2, 0);
    ck("nw2", 32'h20, rd_v);
    req(0, 32'h01450804, 32'h5, 1);
    ck("cw1", 32'h01451010, rd_v);
    apb(1, `OFF_SRC_ID, 32'h00040506);
    req(0, 32'hFF000000, 0, 1);
    ck("mine", 32'h1, {31'h0, service_on});
    ck("who2", 32'h00010203, {8'h0, service_client});
    apb(1, `OFF_SRC_ID, 32'h00010203);
  endtask
  task t_unmapped;
    apb(0, 8'h30, 0);
    ck("slverr", 32'h1, {31'h0, err});
    ck("rd0", 32'h0, rd_v);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(1, `OFF_SRC_ID, 32'h00010203);
    t_enable();
    t_update();
    t_reserved();
    t_fabric();
    t_modes();
    t_narrow();
    t_unmapped();
    results();
  end
endmodule
